// ===== design/bdm_addr_unit.sv
// Banked data memory addressing unit
`timescale 1ns/10ps
`default_nettype none
module bdm_addr_unit
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Watchdog reset in sleep or idle: keeps the bank selection
  input wire logic wdt_sleep_reset_i,
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [bdm_pkg::DATA_W-1:0] wdata_i,
  // Bit operation: set or clear one bit of the addressed byte
  input wire logic bit_op_i,
  input wire logic bit_val_i,
  input wire logic [2:0] bit_idx_i,
  // Other special registers live in the core, reached here by address
  input wire logic [bdm_pkg::DATA_W-1:0] sfr_rdata_i,
  input wire logic sfr_present_i,
  input wire logic sfr_protected_i,
  input wire logic [bdm_pkg::DATA_W-1:0] eeprom_ctrl_rdata_i,
  output logic sfr_wr_o,
  output logic eeprom_ctrl_wr_o,
  output logic [7:0] sfr_addr_o,
  output logic [bdm_pkg::DATA_W-1:0] sfr_wdata_o,
  output logic [bdm_pkg::DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  output logic [bdm_pkg::BANK_W-1:0] bank_sel_o
);
  import bdm_pkg::*;

  // =========================================
  // Address resolution
  logic [7:0] ptr_a;
  logic [7:0] ptr_b;
  logic [BANK_W-1:0] bank_sel;
  logic [7:0] eff_addr;
  logic [BANK_W-1:0] eff_bank;
  logic indirect;
  logic port_hit;
  bdm_region_e region;
  logic [MEM_AW-1:0] mem_addr;
  logic eeprom_hit;
  logic acc_wr;
  logic [DATA_W-1:0] cur_byte;
  logic [DATA_W-1:0] next_byte;

  always_comb
  begin
    indirect = 1'b0;
    eff_addr = addr_i;
    eff_bank = BANK_0;
    if (addr_i == ADDR_PORT_A)
    begin
      indirect = 1'b1;
      eff_addr = ptr_a;
      eff_bank = BANK_0;
    end
    else if (addr_i == ADDR_PORT_B)
    begin
      indirect = 1'b1;
      eff_addr = ptr_b;
      eff_bank = bank_sel;
    end
  end

  assign port_hit = indirect && (eff_bank == BANK_0)
    && (eff_addr == ADDR_PORT_A || eff_addr == ADDR_PORT_B);

  always_comb
  begin
    region = BDM_REGION_NONE;
    mem_addr = '0;
    eeprom_hit = 1'b0;
    unique case (eff_bank)
      BANK_0:
      begin
        if (eff_addr >= ADDR_GP_BASE)
        begin
          region = BDM_REGION_MEM;
          mem_addr = eff_addr - ADDR_GP_BASE;
        end
        else if (port_hit)
        begin
          region = BDM_REGION_NONE;
        end
        else if (eff_addr <= ADDR_BANK_SEL)
        begin
          region = BDM_REGION_LOCAL;
        end
        else if (eff_addr != ADDR_EEPROM_CTRL && sfr_present_i)
        begin
          region = BDM_REGION_SFR;
        end
      end
      BANK_1:
      begin
        if (eff_addr == ADDR_EEPROM_CTRL)
        begin
          region = BDM_REGION_SFR;
          eeprom_hit = 1'b1;
        end
      end
      BANK_5:
      begin
        if (eff_addr <= ADDR_TK_LAST)
        begin
          region = BDM_REGION_MEM;
          mem_addr = TK_BASE + eff_addr;
        end
      end
      BANK_6:
      begin
        if (eff_addr <= ADDR_TK_LAST)
        begin
          region = BDM_REGION_MEM;
          mem_addr = TK6_BASE + eff_addr;
        end
      end
      default:
      begin
        region = BDM_REGION_NONE;
      end
    endcase
  end

  // =========================================
  // Read byte and bit operation merge
  logic [DATA_W-1:0] local_rdata;
  logic [DATA_W-1:0] mem_rdata;

  always_comb
  begin
    local_rdata = ZERO_BYTE;
    if (eff_addr == ADDR_PTR_A)
    begin
      local_rdata = ptr_a;
    end
    else if (eff_addr == ADDR_PTR_B)
    begin
      local_rdata = ptr_b;
    end
    else if (eff_addr == ADDR_BANK_SEL)
    begin
      local_rdata = {{(DATA_W-BANK_W){1'b0}}, bank_sel};
    end
  end

  always_comb
  begin
    cur_byte = ZERO_BYTE;
    unique case (region)
      BDM_REGION_LOCAL: cur_byte = local_rdata;
      BDM_REGION_SFR: cur_byte = eeprom_hit ? eeprom_ctrl_rdata_i : sfr_rdata_i;
      BDM_REGION_MEM: cur_byte = mem_rdata;
      BDM_REGION_NONE: cur_byte = ZERO_BYTE;
    endcase
  end

  // Bit operations merge into the current byte; RAM data is the registered read, or the last-write shadow
  always_comb
  begin
    next_byte = wdata_i;
    if (bit_op_i)
    begin
      next_byte = cur_byte;
      next_byte[bit_idx_i] = bit_val_i;
    end
  end

  assign acc_wr = wr_i && (region != BDM_REGION_NONE);

  // =========================================
  // Memory
  logic [DATA_W-1:0] mem_q;
  logic [MEM_AW-1:0] mem_addr_q;
  logic [DATA_W-1:0] shadow_q;
  logic shadow_vld;

  bdm_ram u_ram
  (
    .clk_sys_i(clk_sys_i),
    .wr_en_i(acc_wr && region == BDM_REGION_MEM),
    .wr_addr_i(mem_addr),
    .wr_data_i(next_byte),
    .rd_addr_i(mem_addr),
    .rd_data_o(mem_q)
  );

  // Last write bypass keeps back-to-back bit ops coherent
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_addr_q <= '0;
      shadow_q <= ZERO_BYTE;
      shadow_vld <= 1'b0;
    end
    else
    begin
      mem_addr_q <= mem_addr;
      shadow_vld <= acc_wr && region == BDM_REGION_MEM;
      shadow_q <= next_byte;
    end
  end

  // Bit ops require the address held for two cycles; read data is registered
  assign mem_rdata = (shadow_vld && mem_addr_q == mem_addr) ? shadow_q : mem_q;

  // =========================================
  // Pointers and bank select
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ptr_a <= ZERO_BYTE;
      ptr_b <= ZERO_BYTE;
    end
    else if (acc_wr && region == BDM_REGION_LOCAL)
    begin
      if (eff_addr == ADDR_PTR_A)
      begin
        ptr_a <= next_byte;
      end
      if (eff_addr == ADDR_PTR_B)
      begin
        ptr_b <= next_byte;
      end
    end
  end

  // Watchdog wake reset spares the bank; its flag must be steady while reset is low
  logic bank_rst_n;
  assign bank_rst_n = rst_n_i || wdt_sleep_reset_i;

  always_ff @(posedge clk_sys_i or negedge bank_rst_n)
  begin
    if (!bank_rst_n)
    begin
      bank_sel <= BANK_SEL_RESET;
    end
    else if (acc_wr && region == BDM_REGION_LOCAL && eff_addr == ADDR_BANK_SEL)
    begin
      bank_sel <= next_byte[BANK_W-1:0];
    end
  end

  // =========================================
  // Outputs
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_o <= ZERO_BYTE;
      rvalid_o <= 1'b0;
      sfr_wr_o <= 1'b0;
      eeprom_ctrl_wr_o <= 1'b0;
      sfr_addr_o <= ZERO_BYTE;
      sfr_wdata_o <= ZERO_BYTE;
      bank_sel_o <= BANK_SEL_RESET;
    end
    else
    begin
      rdata_o <= rd_i ? cur_byte : ZERO_BYTE;
      rvalid_o <= rd_i;
      // Protected registers are refused here, so the core never sees the write
      sfr_wr_o <= acc_wr && region == BDM_REGION_SFR && !eeprom_hit
        && !sfr_protected_i;
      eeprom_ctrl_wr_o <= acc_wr && eeprom_hit;
      sfr_addr_o <= eff_addr;
      sfr_wdata_o <= next_byte;
      bank_sel_o <= bank_sel;
    end
  end

  // =========================================
  // Checks
  a_direct_bank_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !indirect |-> eff_bank == BANK_0) else $error("direct access left bank 0");
  a_port_a_bank_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    addr_i == ADDR_PORT_A |-> eff_bank == BANK_0 && eff_addr == ptr_a)
    else $error("first port left bank 0");
  a_port_b_bank_sel: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    addr_i == ADDR_PORT_B |-> eff_bank == bank_sel && eff_addr == ptr_b)
    else $error("second port bank wrong");
  a_unused_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_i && region == BDM_REGION_NONE |=> rdata_o == ZERO_BYTE)
    else $error("unused read not zero");
  a_port_self_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    port_hit |-> !acc_wr) else $error("indirect port write stored");
  a_bank_sel_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_i && !bit_op_i && addr_i == ADDR_BANK_SEL |=> bank_sel == $past(wdata_i[2:0]))
    else $error("bank select not written");
  a_bank_sel_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    rd_i && addr_i == ADDR_BANK_SEL |=> rdata_o == {5'h00, $past(bank_sel)})
    else $error("bank select read wrong");
  a_protected_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sfr_protected_i && !eeprom_hit |=> !sfr_wr_o) else $error("protected write passed");
  a_bad_bank_none: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    indirect && eff_bank inside {3'h2, 3'h3, 3'h4, 3'h7} |-> region == BDM_REGION_NONE)
    else $error("unimplemented bank hit");
  a_bit_op_one: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    bit_op_i |-> (next_byte ^ cur_byte) == (cur_byte[bit_idx_i] != bit_val_i ?
      8'h01 << bit_idx_i : ZERO_BYTE)) else $error("bit op changed other bits");
endmodule // bdm_addr_unit
`default_nettype wire

// ===== inc/bdm_pkg.sv
// Constants for the banked data memory addressing unit
package bdm_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned BANK_W = 3;
  localparam logic [7:0] ADDR_PORT_A = 8'h00;
  localparam logic [7:0] ADDR_PTR_A = 8'h01;
  localparam logic [7:0] ADDR_PORT_B = 8'h02;
  localparam logic [7:0] ADDR_PTR_B = 8'h03;
  localparam logic [7:0] ADDR_BANK_SEL = 8'h04;
  localparam logic [7:0] ADDR_EEPROM_CTRL = 8'h40;
  localparam logic [7:0] ADDR_GP_BASE = 8'h80;
  localparam logic [7:0] ADDR_TK_LAST = 8'h07;
  localparam logic [7:0] ADDR_SFR_LAST = 8'h7F;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [2:0] BANK_SEL_RESET = 3'h0;
  localparam logic [2:0] BANK_0 = 3'h0;
  localparam logic [2:0] BANK_1 = 3'h1;
  localparam logic [2:0] BANK_5 = 3'h5;
  localparam logic [2:0] BANK_6 = 3'h6;
  localparam int unsigned GP_DEPTH = 128;
  localparam int unsigned GP_AW = 7;
  localparam int unsigned TK_DEPTH = 16;
  localparam int unsigned TK_AW = 4;
  localparam int unsigned MEM_DEPTH = GP_DEPTH + TK_DEPTH;
  localparam int unsigned MEM_AW = 8;
  localparam logic [7:0] TK_BASE = 8'h80;
  localparam logic [7:0] TK6_BASE = 8'h88;
  typedef enum logic [1:0] {
    BDM_REGION_NONE = 2'h0,
    BDM_REGION_LOCAL = 2'h1,
    BDM_REGION_MEM = 2'h3,
    BDM_REGION_SFR = 2'h2
  } bdm_region_e;
endpackage : bdm_pkg

// ===== design/bdm_ram.sv
// Byte memory holding general purpose and touch key data
`timescale 1ns/10ps
`default_nettype none
module bdm_ram
  import bdm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic wr_en_i,
  input wire logic [bdm_pkg::MEM_AW-1:0] wr_addr_i,
  input wire logic [bdm_pkg::DATA_W-1:0] wr_data_i,
  input wire logic [bdm_pkg::MEM_AW-1:0] rd_addr_i,
  output logic [bdm_pkg::DATA_W-1:0] rd_data_o
);
  logic [DATA_W-1:0] mem [MEM_DEPTH];

  // Contents are volatile and are not cleared by reset
  always_ff @(posedge clk_sys_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // bdm_ram
`default_nettype wire

// ===== sim/bdm_core_model.sv
// Core-side special register file facing the addressing unit
`timescale 1ns/10ps
`default_nettype none
module bdm_core_model
  import bdm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic bit_op_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic sfr_wr_i,
  input wire logic eeprom_ctrl_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_present_o,
  output logic sfr_protected_o,
  output logic [7:0] eeprom_ctrl_rdata_o
);
  logic [7:0] regs [0:127];
  logic [7:0] ptr_a;
  logic [7:0] ptr_b;
  logic [2:0] bank;
  logic [7:0] ro_val;
  logic [7:0] eff;
  // ==========================================
  // Mirror of pointers for the lookup
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ptr_a <= 8'h00;
      ptr_b <= 8'h00;
      bank <= 3'h0;
      ro_val <= 8'hA5;
      eeprom_ctrl_rdata_o <= 8'h00;
    end
    else
    begin
      if (wr_i && !bit_op_i && addr_i == ADDR_PTR_A) ptr_a <= wdata_i;
      if (wr_i && !bit_op_i && addr_i == ADDR_PTR_B) ptr_b <= wdata_i;
      if (wr_i && !bit_op_i && addr_i == ADDR_BANK_SEL) bank <= wdata_i[2:0];
      // A leaked write shows up on the next read
      if (sfr_wr_i && sfr_addr_i == 8'h08) ro_val <= sfr_wdata_i;
      if (eeprom_ctrl_wr_i) eeprom_ctrl_rdata_o <= sfr_wdata_i;
    end
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (sfr_wr_i) regs[sfr_addr_i[6:0]] <= sfr_wdata_i;
  end
  // ==========================================
  // Combinational lookup; unused gives junk, not zero
  always_comb
  begin
    eff = (addr_i == ADDR_PORT_A) ? ptr_a : (addr_i == ADDR_PORT_B) ? ptr_b : addr_i;
    sfr_present_o = (addr_i != ADDR_PORT_B || bank == BANK_0) &&
      ((eff >= 8'h05 && eff <= 8'h1E) || (eff >= 8'h41 && eff <= 8'h58));
    sfr_protected_o = sfr_present_o && eff == 8'h08;
    sfr_rdata_o = !sfr_present_o ? 8'hC3 : sfr_protected_o ? ro_val : regs[eff[6:0]];
  end
endmodule // bdm_core_model
`default_nettype wire

// ===== sim/banked_data_memory_addressing_tb.sv
// Self-checking bench for the banked data memory addressing unit
`timescale 1ns/10ps
`default_nettype none
module banked_data_memory_addressing_tb
  import bdm_pkg::*;
;
  typedef struct packed {logic [1:0] op; logic [7:0] a; logic [7:0] d;} bdm_row_s;
  // Op 0 write, 1 read and expect, 2 bit set, 3 bit clear (d = bit number)
  localparam int NROW = 44;
  localparam bdm_row_s ROWS [0:NROW-1] = '{
    '{2'h0,8'h04,8'h07}, '{2'h0,8'h03,8'h10}, '{2'h0,8'h02,8'h33}, '{2'h1,8'h02,8'h00},
    '{2'h0,8'h04,8'hFF}, '{2'h1,8'h04,8'h07}, '{2'h0,8'h04,8'h05}, '{2'h0,8'h03,8'h07},
    '{2'h0,8'h02,8'h5A}, '{2'h0,8'h04,8'h06}, '{2'h0,8'h02,8'hC3}, '{2'h1,8'h02,8'hC3},
    '{2'h0,8'h04,8'h05}, '{2'h1,8'h02,8'h5A}, '{2'h0,8'h03,8'h08}, '{2'h1,8'h02,8'h00},
    '{2'h0,8'h01,8'h87}, '{2'h0,8'h00,8'h9C}, '{2'h1,8'h87,8'h9C}, '{2'h1,8'h01,8'h87},
    '{2'h2,8'h87,8'h00}, '{2'h1,8'h87,8'h9D}, '{2'h3,8'h87,8'h07}, '{2'h1,8'h87,8'h1D},
    '{2'h0,8'h01,8'h02}, '{2'h0,8'h00,8'h11}, '{2'h1,8'h00,8'h00}, '{2'h0,8'h80,8'h01},
    '{2'h1,8'h80,8'h01}, '{2'h0,8'hFF,8'hFE}, '{2'h1,8'hFF,8'hFE}, '{2'h1,8'h20,8'h00},
    '{2'h0,8'h05,8'h66}, '{2'h1,8'h05,8'h66}, '{2'h0,8'h08,8'h00}, '{2'h1,8'h08,8'hA5},
    '{2'h0,8'h04,8'h01}, '{2'h0,8'h03,8'h40}, '{2'h0,8'h02,8'h3C}, '{2'h1,8'h02,8'h3C},
    '{2'h1,8'h40,8'h00}, '{2'h0,8'h02,8'h11}, '{2'h1,8'h02,8'h11}, '{2'h1,8'h02,8'h11}};
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wdt_sleep_reset_i = 1'b0;
  logic rd_i = 1'b0;
  logic wr_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic bit_op_i = 1'b0;
  logic bit_val_i = 1'b0;
  logic [2:0] bit_idx_i = 3'h0;
  logic [7:0] sfr_rdata;
  logic sfr_present;
  logic sfr_protected;
  logic [7:0] eeprom_rdata;
  logic sfr_wr_o;
  logic eeprom_ctrl_wr_o;
  logic [7:0] sfr_addr_o;
  logic [7:0] sfr_wdata_o;
  logic [7:0] rdata_o;
  logic rvalid_o;
  logic [2:0] bank_sel_o;
  int n_mismatch = 0;
  int n_compared = 0;
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  bdm_addr_unit u_bdm_addr_unit (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .wdt_sleep_reset_i(wdt_sleep_reset_i),
    .rd_i(rd_i), .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .bit_op_i(bit_op_i), .bit_val_i(bit_val_i), .bit_idx_i(bit_idx_i),
    .sfr_rdata_i(sfr_rdata), .sfr_present_i(sfr_present), .sfr_protected_i(sfr_protected),
    .eeprom_ctrl_rdata_i(eeprom_rdata), .sfr_wr_o(sfr_wr_o),
    .eeprom_ctrl_wr_o(eeprom_ctrl_wr_o), .sfr_addr_o(sfr_addr_o), .sfr_wdata_o(sfr_wdata_o),
    .rdata_o(rdata_o), .rvalid_o(rvalid_o), .bank_sel_o(bank_sel_o));
  bdm_core_model u_bdm_core_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wr_i(wr_i),
    .bit_op_i(bit_op_i), .addr_i(addr_i), .wdata_i(wdata_i), .sfr_wr_i(sfr_wr_o),
    .eeprom_ctrl_wr_i(eeprom_ctrl_wr_o), .sfr_addr_i(sfr_addr_o), .sfr_wdata_i(sfr_wdata_o),
    .sfr_rdata_o(sfr_rdata), .sfr_present_o(sfr_present), .sfr_protected_o(sfr_protected),
    .eeprom_ctrl_rdata_o(eeprom_rdata));
  // ==========================================
  // Tasks
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Address leads the strobe by a cycle, as the RAM read needs
  task automatic acc(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
    addr_i = a;
    wdata_i = d;
    bit_op_i = op[1];
    bit_val_i = ~op[0];
    bit_idx_i = d[2:0];
    @(negedge clk_sys_i);
    rd_i = (op == 2'h1);
    wr_i = (op != 2'h1);
    @(negedge clk_sys_i);
    rd_i = 1'b0;
    wr_i = 1'b0;
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (4) @(negedge clk_sys_i);
    rst_n_i = 1'b1;
    check({6'h00, bank_sel_o}, 9'h000);
    acc(2'h1, ADDR_BANK_SEL, 8'h00);
    check({rvalid_o, rdata_o}, 9'h100);
    for (int i = 0; i < NROW; i++)
    begin
      acc(ROWS[i].op, ROWS[i].a, ROWS[i].d);
      if (ROWS[i].op == 2'h1)
        check({rvalid_o, rdata_o}, {1'b1, ROWS[i].d});
    end
    check({6'h00, bank_sel_o}, 9'h001);
    rst_n_i = 1'b0;
    @(negedge clk_sys_i);
    check({6'h00, bank_sel_o}, 9'h000);
    rst_n_i = 1'b1;
    acc(2'h1, ADDR_PTR_B, 8'h00);
    check({rvalid_o, rdata_o}, 9'h100);
    acc(2'h1, ADDR_PORT_B, 8'h00);
    check({rvalid_o, rdata_o}, 9'h100);
    // Watchdog wake reset must keep the bank selection
    acc(2'h0, ADDR_BANK_SEL, 8'h05);
    wdt_sleep_reset_i = 1'b1;
    rst_n_i = 1'b0;
    @(negedge clk_sys_i);
    check({6'h00, bank_sel_o}, 9'h000);
    rst_n_i = 1'b1;
    wdt_sleep_reset_i = 1'b0;
    acc(2'h1, ADDR_BANK_SEL, 8'h00);
    check({rvalid_o, rdata_o}, 9'h105);
    check({6'h00, bank_sel_o}, 9'h005);
    wrap_up();
  end
  // Roughly 50 accesses of two cycles each; ample margin
  initial
  begin
    #3000;
    n_mismatch++;
    wrap_up();
  end
endmodule // banked_data_memory_addressing_tb
`default_nettype wire
